// file: hw/flash_lock_device.sv
// flash end: block lock bits, write enable latch and security registers
`default_nettype none
module flash_lock_device #(
    parameter int BLOCKS = flash_lock_pkg::BLOCKS
) (
    input wire logic clock,
    input wire logic rstn,
    spi_link_if.device_end link,
    input wire logic protect_scheme_select,
    input wire logic protect_complement,
    input wire logic sector_granularity,
    input wire logic top_bottom_select,
    input wire logic [2:0] protect_range_bits,
    input wire logic [23:0] check_addr,
    output logic check_writable,
    input wire logic [8:0] otp_rd_addr,
    output logic [7:0] otp_rd_data,
    output logic write_enable_latch,
    output logic [3:0] otp_locked
);
    localparam int BW = $clog2(BLOCKS);
    localparam int OB = flash_lock_pkg::OTP_BYTES;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    logic [1:0] cs_s_r, sck_s_r, mosi_s_r;
    logic cs_d_r, sck_d_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cs_s_r <= 2'h3;
            sck_s_r <= 2'h0;
            mosi_s_r <= 2'h0;
            cs_d_r <= 1'b1;
            sck_d_r <= 1'b0;
        end else begin
            cs_s_r <= {cs_s_r[0], link.cs_n};
            sck_s_r <= {sck_s_r[0], link.sck};
            mosi_s_r <= {mosi_s_r[0], link.mosi};
            cs_d_r <= cs_s_r[1];
            sck_d_r <= sck_s_r[1];
        end
    end
    logic cs_fall, cs_rise, sck_rise, sck_fall, in_bit;
    assign cs_fall = !cs_s_r[1] && cs_d_r;
    assign cs_rise = cs_s_r[1] && !cs_d_r;
    assign sck_rise = sck_s_r[1] && !sck_d_r && !cs_s_r[1];
    assign sck_fall = !sck_s_r[1] && sck_d_r && !cs_s_r[1];
    assign in_bit = mosi_s_r[1];

    ////////////////////////////////////////////////////////////////////
    // bit and byte counting, opcode and address capture
    logic [31:0] sr_r;
    logic [2:0] phase_r;
    logic [7:0] byte_cnt_r;
    logic [7:0] opcode_r;
    logic [23:0] addr_r;
    logic byte_done;
    assign byte_done = sck_rise && (phase_r == 3'd7);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sr_r <= 32'h0;
            phase_r <= 3'h0;
            byte_cnt_r <= 8'h0;
        end else if (cs_fall) begin
            phase_r <= 3'h0;
            byte_cnt_r <= 8'h0;
        end else if (sck_rise) begin
            sr_r <= {sr_r[30:0], in_bit};
            phase_r <= phase_r + 3'd1;
            // saturate so long data phases keep their byte alignment
            if (phase_r == 3'd7 && byte_cnt_r != 8'hff)
                byte_cnt_r <= byte_cnt_r + 8'd1;
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            opcode_r <= 8'h0;
            addr_r <= 24'h0;
        end else if (byte_done && byte_cnt_r == 8'd0) begin
            opcode_r <= {sr_r[6:0], in_bit};
        end else if (byte_done && byte_cnt_r == 8'd3) begin
            addr_r <= {sr_r[22:0], in_bit};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // end-of-frame decode
    logic aligned, op_seen, addr_seen, wel_r;
    logic do_unlock, do_glock, do_gunlock, do_otp;
    assign aligned = (phase_r == 3'd0);
    assign op_seen = byte_cnt_r >= 8'd1;
    assign addr_seen = byte_cnt_r >= 8'd4;
    assign do_unlock = cs_rise && aligned && wel_r && addr_seen
        && (opcode_r == flash_lock_pkg::OP_UNLOCK);
    assign do_glock = cs_rise && aligned && wel_r && op_seen
        && (opcode_r == flash_lock_pkg::OP_GLOCK);
    assign do_gunlock = cs_rise && aligned && wel_r && op_seen
        && (opcode_r == flash_lock_pkg::OP_GUNLOCK);
    logic [1:0] otp_sel_r;
    assign do_otp = cs_rise && aligned && wel_r && addr_seen
        && (opcode_r == flash_lock_pkg::OP_OTP_PROG) && !otp_locked[otp_sel_r];

    ////////////////////////////////////////////////////////////////////
    // write enable latch
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wel_r <= 1'b0;
        end else if (cs_rise && op_seen) begin
            if (aligned && opcode_r == flash_lock_pkg::OP_WREN)
                wel_r <= 1'b1;
            else if (aligned && opcode_r == flash_lock_pkg::OP_WRDI)
                wel_r <= 1'b0;
            else if (do_unlock || do_glock || do_gunlock || do_otp)
                wel_r <= 1'b0;
            // incomplete security program address or data byte drops the latch too
            else if (opcode_r == flash_lock_pkg::OP_OTP_PROG && (!aligned || !addr_seen))
                wel_r <= 1'b0;
        end
    end
    assign write_enable_latch = wel_r;

    ////////////////////////////////////////////////////////////////////
    // block lock bits
    logic [BLOCKS-1:0] lock_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lock_r <= {BLOCKS{flash_lock_pkg::LOCK_RESET}};
        end else if (do_glock) begin
            lock_r <= {BLOCKS{1'b1}};
        end else if (do_gunlock) begin
            lock_r <= {BLOCKS{1'b0}};
        end else if (do_unlock) begin
            lock_r[addr_r[flash_lock_pkg::BLOCK_LSB +: BW]] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // lock-status read out
    logic reading, status_bit, miso_r, miso_oe_r;
    assign reading = flash_lock_pkg::is_rdlock(opcode_r) && addr_seen;
    assign status_bit = lock_r[addr_r[flash_lock_pkg::BLOCK_LSB +: BW]];
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            miso_r <= 1'b0;
            miso_oe_r <= 1'b0;
        end else if (cs_s_r[1]) begin
            miso_r <= 1'b0;
            miso_oe_r <= 1'b0;
        end else if (sck_fall && reading) begin
            miso_oe_r <= 1'b1;
            miso_r <= (phase_r == 3'd7) ? status_bit : 1'b0;
        end
    end
    assign link.miso = miso_r;
    assign link.miso_oe = miso_oe_r;

    ////////////////////////////////////////////////////////////////////
    // security registers: program buffer and storage
    logic [7:0] buf_r [OB];
    logic [OB-1:0] buf_vld_r;
    logic [6:0] ofs_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            buf_vld_r <= '0;
            ofs_r <= 7'h0;
            otp_sel_r <= 2'h0;
        end else if (cs_fall) begin
            buf_vld_r <= '0;
        end else if (byte_done && byte_cnt_r == 8'd3) begin
            ofs_r <= {sr_r[5:0], in_bit};
            otp_sel_r <= sr_r[7:6];
        end else if (byte_done && addr_seen && opcode_r == flash_lock_pkg::OP_OTP_PROG) begin
            // data wraps inside the selected register
            buf_vld_r[ofs_r] <= 1'b1;
            ofs_r <= ofs_r + 7'd1;
        end
    end
    always_ff @(posedge clock) begin
        if (byte_done && addr_seen)
            buf_r[ofs_r] <= {sr_r[6:0], in_bit};
    end

    logic [7:0] otp_mem_r [flash_lock_pkg::OTP_REGS * OB];
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < flash_lock_pkg::OTP_REGS * OB; i++)
                otp_mem_r[i] <= flash_lock_pkg::ERASED;
        end else if (do_otp) begin
            // one-time cells only clear bits, so program is an and
            for (int i = 0; i < OB; i++)
                if (buf_vld_r[i])
                    otp_mem_r[{otp_sel_r, 7'(i)}] <= otp_mem_r[{otp_sel_r, 7'(i)}] & buf_r[i];
        end
    end
    assign otp_locked[0] = 1'b1;
    for (genvar r = 1; r < flash_lock_pkg::OTP_REGS; r++) begin : g_sl
        assign otp_locked[r] = otp_mem_r[{2'(r), 7'h7f}] != flash_lock_pkg::ERASED;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            otp_rd_data <= 8'h0;
        else
            otp_rd_data <= otp_mem_r[otp_rd_addr];
    end

    ////////////////////////////////////////////////////////////////////
    // program/erase permission for the array
    function automatic logic range_prot(input logic [20:0] a, input logic [2:0] bp,
                                        input logic sec, input logic tb, input logic cmp);
        logic [21:0] len;
        logic hit;
        len = (sec ? flash_lock_pkg::SMALL_UNIT : flash_lock_pkg::LARGE_UNIT) << (bp - 3'd1);
        if (bp == 3'd0)
            hit = 1'b0;
        else if (bp == 3'd7 || len >= flash_lock_pkg::MEM_SIZE)
            hit = 1'b1;
        else if (tb)
            hit = {1'b0, a} < len;
        else
            hit = {1'b0, a} >= (flash_lock_pkg::MEM_SIZE - len);
        return hit ^ cmp;
    endfunction : range_prot

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            check_writable <= 1'b0;
        else if (protect_scheme_select)
            check_writable <= !lock_r[check_addr[flash_lock_pkg::BLOCK_LSB +: BW]];
        else
            check_writable <= !range_prot(check_addr[20:0], protect_range_bits,
                sector_granularity, top_bottom_select, protect_complement);
    end
endmodule : flash_lock_device
`default_nettype wire

// file: hw/flash_lock_pkg.sv
// constants shared by both ends of the block-lock serial link
// Summary of operation
// - unlock opcode, eight clocks, MSB first
// - unlock takes 24-bit address, A23 first
// - lock commands act at chip-select rise, clear latch
// - unaligned chip-select rise aborts, nothing changes; a security program still clears the latch
// - host sends whole opcode and address first
// - all block lock bits reset to locked
// - both lock-status read opcodes behave identically
// - block locks apply only under scheme select
// - status byte MSB first, bit0 is lock
// - status byte repeats while chip select low
// - status covers the aligned 4 kB region
// - locked block refuses program and erase
// - global lock sets every lock bit
// - global unlock clears every lock bit
// - global commands need write enable latch set
// - global commands are a single opcode byte
// - four separate 128-byte one-time registers
// - register 0 factory, users 1 to 3
// - security program needs write enable latch
// - security program opcode plus three address bytes
// - host must not trust lock-status for protection
// - address 8:7 picks register, 6:0 byte
`default_nettype none
package flash_lock_pkg;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_UNLOCK = 8'h39;
    localparam logic [7:0] OP_RDLOCK_A = 8'h3c;
    localparam logic [7:0] OP_RDLOCK_B = 8'h3d;
    localparam logic [7:0] OP_GLOCK = 8'h7e;
    localparam logic [7:0] OP_GUNLOCK = 8'h98;
    localparam logic [7:0] OP_OTP_PROG = 8'h9b;
    localparam int ADDR_W = 24;
    localparam int MEM_ADDR_W = 21;
    localparam int BLOCK_LSB = 12;
    localparam int BLOCKS = 512;
    localparam int OTP_REGS = 4;
    localparam int OTP_BYTES = 128;
    localparam int OTP_OFS_W = 7;
    localparam int OTP_SEL_W = 2;
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic LOCK_RESET = 1'b1;
    localparam logic [21:0] MEM_SIZE = 22'h200000;
    localparam logic [21:0] SMALL_UNIT = 22'h001000;
    localparam logic [21:0] LARGE_UNIT = 22'h010000;
    localparam int CLK_NS = 5;
    localparam int SCK_HALF_NS = 60;
    localparam int SCK_HALF_CYC = SCK_HALF_NS / CLK_NS;

    // number of address bytes after each opcode
    function automatic logic [1:0] addr_len(input logic [7:0] op);
        unique case (op)
            OP_UNLOCK, OP_RDLOCK_A, OP_RDLOCK_B, OP_OTP_PROG: addr_len = 2'd3;
            default: addr_len = 2'd0;
        endcase
    endfunction : addr_len

    function automatic logic is_rdlock(input logic [7:0] op);
        return (op == OP_RDLOCK_A) || (op == OP_RDLOCK_B);
    endfunction : is_rdlock
endpackage : flash_lock_pkg
`default_nettype wire

// file: hw/spi_link_if.sv
// serial link between the host controller and the flash lock logic
`default_nettype none
interface spi_link_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    modport host_end (
        output cs_n,
        output sck,
        output mosi,
        input miso
    );
    modport device_end (
        input cs_n,
        input sck,
        input mosi,
        output miso,
        output miso_oe
    );
endinterface : spi_link_if
`default_nettype wire

// file: hw/flash_lock_host.sv
// host end: frames commands onto the serial link, sck from a divider
`default_nettype none
module flash_lock_host #(
    parameter int HALF = flash_lock_pkg::SCK_HALF_CYC
) (
    input wire logic clock,
    input wire logic rstn,
    spi_link_if.host_end link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_opcode,
    input wire logic [23:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic [7:0] cmd_data_bytes,
    output logic [7:0] rd_data,
    output logic rd_valid
);
    typedef enum logic [2:0] {IDLE, SETUP, HIGH, LOW, TRAIL, GAP} state_type;
    state_type state_r;
    logic [1:0] miso_s_r;
    logic [15:0] div_r;
    logic tick;
    logic [7:0] op_r, fop_r, wdata_r, nbytes_r;
    logic [23:0] addr_r;
    logic pre_r;
    logic [11:0] idx_r, total_r;
    logic [7:0] rx_r;
    logic cs_n_r, sck_r, mosi_r;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            miso_s_r <= 2'h0;
        else
            miso_s_r <= {miso_s_r[0], link.miso};
    end
    assign tick = (div_r == 16'(HALF - 1));
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            div_r <= 16'h0;
        else if (state_r == IDLE || tick)
            div_r <= 16'h0;
        else
            div_r <= div_r + 16'd1;
    end

    // frame spans whole header and data
    function automatic logic [11:0] frame_bits(input logic [7:0] op, input logic [7:0] n);
        return 12'd8 * (12'd1 + 12'(flash_lock_pkg::addr_len(op)) + 12'(n));
    endfunction : frame_bits

    function automatic logic bit_at(input logic [11:0] i, input logic [7:0] op,
                                    input logic [23:0] a, input logic [7:0] d);
        logic [31:0] hdr;
        hdr = {op, a};
        if (i < 12'd8 + 12'd8 * 12'(flash_lock_pkg::addr_len(op)))
            return hdr[5'd31 - i[4:0]];
        else if (op == flash_lock_pkg::OP_OTP_PROG)
            return d[3'd7 - i[2:0]];
        else
            return 1'b0;
    endfunction : bit_at

    logic needs_wel;
    assign needs_wel = (cmd_opcode == flash_lock_pkg::OP_GLOCK)
        || (cmd_opcode == flash_lock_pkg::OP_GUNLOCK)
        || (cmd_opcode == flash_lock_pkg::OP_UNLOCK)
        || (cmd_opcode == flash_lock_pkg::OP_OTP_PROG);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= IDLE;
            cs_n_r <= 1'b1;
            sck_r <= 1'b0;
            mosi_r <= 1'b0;
            op_r <= 8'h0;
            fop_r <= 8'h0;
            addr_r <= 24'h0;
            wdata_r <= 8'h0;
            nbytes_r <= 8'h0;
            pre_r <= 1'b0;
            idx_r <= 12'h0;
            total_r <= 12'h0;
            rx_r <= 8'h0;
            rd_data <= 8'h0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            unique case (state_r)
                IDLE: if (cmd_valid) begin
                    op_r <= cmd_opcode;
                    addr_r <= cmd_addr;
                    wdata_r <= cmd_wdata;
                    nbytes_r <= cmd_data_bytes;
                    pre_r <= needs_wel;
                    fop_r <= needs_wel ? flash_lock_pkg::OP_WREN : cmd_opcode;
                    total_r <= needs_wel ? 12'd8 : frame_bits(cmd_opcode, cmd_data_bytes);
                    mosi_r <= needs_wel ? 1'b0 : cmd_opcode[7];
                    idx_r <= 12'h0;
                    cs_n_r <= 1'b0;
                    state_r <= SETUP;
                end
                SETUP, LOW: if (tick) begin
                    sck_r <= 1'b1;
                    rx_r <= {rx_r[6:0], miso_s_r[1]};
                    state_r <= HIGH;
                end
                HIGH: if (tick) begin
                    sck_r <= 1'b0;
                    if (idx_r == total_r - 12'd1) begin
                        state_r <= TRAIL;
                    end else begin
                        idx_r <= idx_r + 12'd1;
                        mosi_r <= bit_at(idx_r + 12'd1, fop_r, addr_r, wdata_r);
                        state_r <= LOW;
                    end
                end
                TRAIL: if (tick) begin
                    // chip select only rises on a byte boundary
                    cs_n_r <= 1'b1;
                    mosi_r <= 1'b0;
                    rd_valid <= flash_lock_pkg::is_rdlock(fop_r);
                    // status only reported, never acted on
                    rd_data <= rx_r;
                    state_r <= GAP;
                end
                GAP: if (tick) begin
                    if (pre_r) begin
                        pre_r <= 1'b0;
                        fop_r <= op_r;
                        total_r <= frame_bits(op_r, nbytes_r);
                        mosi_r <= op_r[7];
                        idx_r <= 12'h0;
                        cs_n_r <= 1'b0;
                        state_r <= SETUP;
                    end else begin
                        state_r <= IDLE;
                    end
                end
            endcase
        end
    end
    assign cmd_ready = (state_r == IDLE);
    assign link.cs_n = cs_n_r;
    assign link.sck = sck_r;
    assign link.mosi = mosi_r;
endmodule : flash_lock_host
`default_nettype wire

// file: verification/flash_lock_properties.sv
// link checker: framing, clock phase and read-out timing on the serial link
`default_nettype none
module flash_lock_properties (
    input wire logic clock,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    logic sck_d_r;
    logic [7:0] bits_r;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sck_d_r <= 1'b0;
        end else begin
            sck_d_r <= sck;
        end
    end

    // rising serial clock edges seen inside the current frame
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bits_r <= 8'h00;
        end else if (cs_n) begin
            bits_r <= 8'h00;
        end else if (sck && !sck_d_r) begin
            bits_r <= bits_r + 8'h01;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////
    AST_FRAME_WHOLE_BYTES: assert property (
        $rose(cs_n) |-> (bits_r[2:0] == 3'h0)) else $error("frame ended off a byte boundary");
    AST_SCK_IDLE_LOW: assert property (
        cs_n |-> !sck) else $error("serial clock not low outside a frame");
    AST_MOSI_HELD_HIGH: assert property (
        (sck && sck_d_r) |-> $stable(mosi)) else $error("mosi moved while clock high");
    AST_MISO_HELD_HIGH: assert property (
        (sck && sck_d_r && !cs_n) |-> $stable(miso)) else $error("miso moved while clock high");
    AST_SCK_HIGH_MIN: assert property (
        $rose(sck) |-> sck[*4]) else $error("serial clock high phase too short");
    AST_CS_GAP: assert property (
        $rose(cs_n) |-> cs_n[*4]) else $error("chip select high gap too short");
    AST_OE_AFTER_ADDR: assert property (
        $rose(miso_oe) |-> (bits_r == 8'd32)) else $error("read-out began at wrong bit");
    AST_OE_DROPS: assert property (
        $rose(cs_n) |-> ##[1:6] !miso_oe) else $error("miso still driven after frame");
endmodule : flash_lock_properties
`default_nettype wire

// file: verification/flash_block_lock_commands_tb.sv
// testbench: host and flash ends joined, plus a bit-banged second link
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module flash_block_lock_commands_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    logic [7:0] cmd_opcode = 8'h00;
    logic [23:0] cmd_addr = 24'h000000;
    logic [7:0] cmd_wdata = 8'h00;
    logic [7:0] cmd_data_bytes = 8'h00;
    logic [7:0] rd_data;
    logic rd_valid;
    logic protect_scheme_select = 1'b1;
    logic [2:0] protect_range_bits = 3'h0;
    logic protect_complement = 1'b0;
    logic sector_granularity = 1'b0;
    logic top_bottom_select = 1'b0;
    logic rd_seen = 1'b0;
    logic [23:0] check_addr = 24'h000000;
    logic [8:0] otp_rd_addr = 9'h000;
    logic check_writable;
    logic check_writable_b;
    logic [7:0] otp_rd_data;
    logic write_enable_latch;
    logic write_enable_latch_b;
    logic [3:0] otp_locked;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;

    spi_link_if link();
    spi_link_if link2();
    flash_lock_host #(.HALF(6)) u_flash_lock_host (
        .clock(clock), .rstn(rstn), .link(link), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_data_bytes(cmd_data_bytes), .rd_data(rd_data),
        .rd_valid(rd_valid));
    flash_lock_device u_flash_lock_device (
        .clock(clock), .rstn(rstn), .link(link), .protect_scheme_select(protect_scheme_select),
        .protect_complement(protect_complement), .sector_granularity(sector_granularity),
        .top_bottom_select(top_bottom_select), .protect_range_bits(protect_range_bits),
        .check_addr(check_addr),
        .check_writable(check_writable), .otp_rd_addr(otp_rd_addr), .otp_rd_data(otp_rd_data),
        .write_enable_latch(write_enable_latch), .otp_locked(otp_locked));
    // second end faces the bench driver, which breaks framing on purpose
    flash_lock_device u_flash_lock_device_b (
        .clock(clock), .rstn(rstn), .link(link2), .protect_scheme_select(protect_scheme_select),
        .protect_complement(protect_complement), .sector_granularity(sector_granularity),
        .top_bottom_select(top_bottom_select), .protect_range_bits(protect_range_bits),
        .check_addr(check_addr),
        .check_writable(check_writable_b), .otp_rd_addr(otp_rd_addr), .otp_rd_data(),
        .write_enable_latch(write_enable_latch_b), .otp_locked());
    flash_lock_properties u_flash_lock_properties (
        .clock(clock), .rstn(rstn), .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi),
        .miso(link.miso), .miso_oe(link.miso_oe));

    always #2.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // a hang counts as a mismatch
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] n,
                       input logic [7:0] d);
        int k;
        rd_seen = 1'b0;
        cmd_opcode <= op;
        cmd_addr <= a;
        cmd_data_bytes <= n;
        cmd_wdata <= d;
        cmd_valid <= 1'b1;
        @(posedge clock);
        cmd_valid <= 1'b0;
        k = 0;
        do begin
            @(posedge clock);
            #1;
            if (rd_valid === 1'b1) rd_seen = 1'b1;
            k++;
        end while (cmd_ready !== 1'b1 && k < 4000);
        if (cmd_ready !== 1'b1) bad_count++;
        @(posedge clock);
    endtask : cmd

    task automatic status(input logic [7:0] op, input logic [23:0] a, input logic [7:0] n,
                          input logic [7:0] exp);
        cmd(op, a, n, 8'h00);
        `CHK(rd_seen, 1'b1);
        `CHK(rd_data, exp);
    endtask : status

    task automatic probe(input logic [23:0] a);
        check_addr <= a;
        otp_rd_addr <= a[8:0];
        repeat (3) @(posedge clock);
    endtask : probe

    // link clock of 125 ns; mosi scrambled after release so stale bits never match
    task automatic bb(input logic [15:0] v, input int n);
        link2.cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            link2.mosi <= v[15 - i];
            repeat (13) @(posedge clock);
            link2.sck <= 1'b1;
            repeat (12) @(posedge clock);
            link2.sck <= 1'b0;
        end
        repeat (13) @(posedge clock);
        link2.cs_n <= 1'b1;
        link2.mosi <= ~link2.mosi;
        repeat (8) @(posedge clock);
    endtask : bb

    ////////////////////////////////////////////////////////////////////////
    initial begin
        link2.cs_n = 1'b1;
        link2.sck = 1'b0;
        link2.mosi = 1'b0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        status(flash_lock_pkg::OP_RDLOCK_A, 24'h001234, 8'h01, 8'h01);
        probe(24'h001234);
        `CHK(check_writable, 1'b0);
        cmd(flash_lock_pkg::OP_UNLOCK, 24'h001234, 8'h00, 8'h00);
        `CHK(rd_seen, 1'b0);
        `CHK(write_enable_latch, 1'b0);
        status(flash_lock_pkg::OP_RDLOCK_B, 24'h001fff, 8'h03, 8'h00);
        status(flash_lock_pkg::OP_RDLOCK_A, 24'h001000, 8'h01, 8'h00);
        status(flash_lock_pkg::OP_RDLOCK_B, 24'h000fff, 8'h01, 8'h01);
        status(flash_lock_pkg::OP_RDLOCK_A, 24'h002000, 8'h01, 8'h01);
        probe(24'h001800);
        `CHK(check_writable, 1'b1);
        cmd(flash_lock_pkg::OP_UNLOCK, 24'h1ff000, 8'h00, 8'h00);
        probe(24'h1fffff);
        `CHK(check_writable, 1'b1);
        probe(24'h1fefff);
        `CHK(check_writable, 1'b0);
        // global commands; the host prefixes its own write enable frame
        cmd(flash_lock_pkg::OP_GUNLOCK, 24'h000000, 8'h00, 8'h00);
        `CHK(write_enable_latch, 1'b0);
        for (int i = 0; i < 3; i++) begin
            status(flash_lock_pkg::OP_RDLOCK_A, 24'h0ff000 * i[23:0], 8'h01, 8'h00);
        end
        probe(24'h0a5000);
        `CHK(check_writable, 1'b1);
        protect_scheme_select <= 1'b0;
        protect_range_bits <= 3'h7;
        probe(24'h0a5000);
        `CHK(check_writable, 1'b0);
        protect_range_bits <= 3'h1;
        top_bottom_select <= 1'b1;
        protect_complement <= 1'b1;
        sector_granularity <= 1'b1;
        probe(24'h00ffff);
        `CHK(check_writable, 1'b0);
        probe(24'h000fff);
        `CHK(check_writable, 1'b1);
        protect_complement <= 1'b0;
        cmd(flash_lock_pkg::OP_GLOCK, 24'h000000, 8'h00, 8'h00);
        status(flash_lock_pkg::OP_RDLOCK_B, 24'h1ff000, 8'h01, 8'h01);
        protect_range_bits <= 3'h0;
        probe(24'h0a5000);
        `CHK(check_writable, 1'b1);
        protect_scheme_select <= 1'b1;
        probe(24'h0a5000);
        `CHK(check_writable, 1'b0);
        // security registers; upper address bits must be ignored
        cmd(flash_lock_pkg::OP_OTP_PROG, 24'hfe0100, 8'h02, 8'ha5);
        probe(24'h000101);
        `CHK(otp_rd_data, 8'ha5);
        probe(24'h0000ff);
        `CHK(otp_rd_data, 8'hff);
        `CHK(otp_locked, 4'b0001);
        cmd(flash_lock_pkg::OP_OTP_PROG, 24'h00017f, 8'h01, 8'h00);
        `CHK(otp_locked, 4'b0101);
        cmd(flash_lock_pkg::OP_OTP_PROG, 24'h000100, 8'h01, 8'h00);
        probe(24'h000100);
        `CHK(otp_rd_data, 8'ha5);
        `CHK(write_enable_latch, 1'b1);
        cmd(flash_lock_pkg::OP_OTP_PROG, 24'h000005, 8'h01, 8'h00);
        probe(24'h000005);
        `CHK(otp_rd_data, 8'hff);
        // second end: no write enable, then frames cut off the byte boundary
        bb(16'h9800, 8);
        probe(24'h003000);
        `CHK(check_writable_b, 1'b0);
        bb(16'h0600, 8);
        `CHK(write_enable_latch_b, 1'b1);
        bb(16'h9800, 7);
        bb(16'h9800, 9);
        probe(24'h003000);
        `CHK(check_writable_b, 1'b0);
        `CHK(write_enable_latch_b, 1'b1);
        bb(16'h9800, 8);
        probe(24'h003000);
        `CHK(check_writable_b, 1'b1);
        `CHK(write_enable_latch_b, 1'b0);
        summarize();
    end
endmodule : flash_block_lock_commands_tb
`default_nettype wire
